// File: bench/controller_model.sv
// Purpose: Behavioural controller facing the transient sense stage
// Assumes: Alarms and fault alert arrive on the bench clock
// Notes:   Two phases, the second one period over the phase count later; exit count is under 100ns
`timescale 1ns/1ps
module controller_model #(
	parameter int         EXIT_CYC   = 3,
	parameter int         PERIOD_CYC = 8,
	parameter int         PHASES     = 2,
	parameter int         OVL_CYC    = 8,
	parameter logic [9:0] OVL_LIMIT  = 10'h3C0
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// From the sense stage
	input wire logic        overshootAlarm,
	input wire logic        undershootAlarm,
	input wire logic        faultAlert,
	// Synchronous pulses
	input wire logic        highPulse,
	input wire logic        lowPulse,
	// Summed load current
	input wire logic [9:0]  loadSum,
	// Gate outputs and mode
	output logic            pwm,
	output logic            pwmLag,
	output logic            lowGate,
	output logic [1:0]      transientMode
);
	localparam int STAGGER = PERIOD_CYC / PHASES;

	// ==========================================================
	// Mode, exit counter and shutdown latch
	logic [1:0] modeQ;
	logic [1:0] modeD;
	logic [3:0] cntQ;
	logic [3:0] cntD;
	logic       downQ;
	logic       downD;
	logic [3:0] ovlQ;
	logic [3:0] ovlD;
	always_comb begin
		modeD = modeQ;
		cntD = cntQ;
		ovlD = (loadSum > OVL_LIMIT) ? ovlQ + 4'h1 : 4'h0;
		downD = downQ | faultAlert | (ovlQ == 4'(OVL_CYC));
		if (modeQ == 2'h0) begin
			if (overshootAlarm) begin
				modeD = 2'h1;
				cntD = 4'(EXIT_CYC);
			end else if (undershootAlarm) begin
				modeD = 2'h2;
				cntD = 4'(EXIT_CYC);
			end
		end else if (overshootAlarm || undershootAlarm) begin
			cntD = 4'(EXIT_CYC);
		end else if (cntQ == 4'h0) begin
			modeD = 2'h0;
		end else begin
			cntD = cntQ - 4'h1;
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			modeQ <= 2'h0;
			cntQ <= 4'h0;
			downQ <= 1'b0;
			ovlQ <= 4'h0;
		end else begin
			modeQ <= modeD;
			cntQ <= cntD;
			downQ <= downD;
			ovlQ <= ovlD;
		end
	end
	// ==========================================================
	// Second phase, one period over the phase count later
	logic [STAGGER-1:0] lagQ;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lagQ <= '0;
		end else begin
			lagQ <= {lagQ[STAGGER-2:0], highPulse};
		end
	end
	assign pwmLag = !downQ && modeQ != 2'h1 && (lagQ[STAGGER-1] || (modeQ == 2'h2 && undershootAlarm));
	// ==========================================================
	// Gate combination
	always_comb begin
		pwm = highPulse;
		lowGate = lowPulse;
		if (downQ) begin
			pwm = 1'b0;
			lowGate = 1'b0;
		end else if (modeQ == 2'h1) begin
			pwm = 1'b0;
			lowGate = lowPulse | overshootAlarm;
		end else if (modeQ == 2'h2) begin
			pwm = highPulse | undershootAlarm;
			lowGate = 1'b0;
		end
	end
	assign transientMode = modeQ;
endmodule // controller_model

// File: bench/tb.sv
// Purpose: Self-checking bench for the transient sense and protection stage
// Assumes: Registers reached over Avalon-MM with waitrequest
// Notes:   Controller model closes the high-side command loop
`timescale 1ns/1ps
module tb;
	// ==========================================================
	// Signals
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [9:0]  senseCode = 10'h000;
	logic        senseValid = 1'b0;
	logic [9:0]  curCode = 10'h000;
	logic        curValid = 1'b0;
	logic        uvPin = 1'b0;
	logic        otPin = 1'b0;
	logic        highPulse = 1'b0;
	logic        pwm;
	logic        lagPwm;
	logic        overAlarm;
	logic        underAlarm;
	logic        gate;
	logic        alert;
	logic [1:0]  mode;
	logic [31:0] rd;
	logic [7:0]  peak [4] = '{transient_pkg::PEAK_LVL0, transient_pkg::PEAK_LVL1,
		transient_pkg::PEAK_LVL2, transient_pkg::PEAK_LVL3};
	int          failCount = 0;
	int          checkCount = 0;

	initial begin
		forever #10 clock = ~clock;
	end

	// ==========================================================
	// Instances
	transient_response_fault_control #(.SENSE_W(10), .CUR_W(10)) transient_response_fault_control_i (
		.clock(clock), .arst_n(arst_n), .ce(1'b1), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
		.senseCode(senseCode), .senseValid(senseValid), .curCode(curCode), .curValid(curValid),
		.highSideCmd(pwm), .inputUnderVoltPin(uvPin), .overTempPin(otPin), .overshootAlarm(overAlarm),
		.undershootAlarm(underAlarm), .highSideGate(gate), .faultAlert(alert));
	controller_model controller_model_i (
		.clock(clock), .arst_n(arst_n), .overshootAlarm(overAlarm), .undershootAlarm(underAlarm),
		.faultAlert(alert), .highPulse(highPulse), .lowPulse(1'b0), .loadSum(curCode), .pwm(pwm),
		.pwmLag(lagPwm), .lowGate(), .transientMode(mode));

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic access(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
		address <= adr;
		writedata <= dat;
		write <= wr;
		read <= !wr;
		@(posedge clock);
		while (waitrequest !== 1'b0) begin
			@(posedge clock);
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
		access(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask
	task automatic sample(input logic [9:0] code);
		senseCode <= code;
		senseValid <= 1'b1;
		@(posedge clock);
		senseValid <= 1'b0;
		@(posedge clock);
	endtask
	task automatic curPulse(input logic [9:0] code);
		curCode <= code;
		curValid <= 1'b1;
		@(posedge clock);
		curValid <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task automatic finalReport;
		$display("Checks %0d, mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		rdChk(transient_pkg::ALARM_OFS_OFS, 32'h0404);
		rdChk(transient_pkg::PROT_OFS_OFS, 32'h1F1F);
		rdChk(transient_pkg::FAULT_OFS, 32'h0);
		access(1'b1, 8'h40, 32'hFFFF);
		rdChk(8'h40, 32'h0);
		$display("Test reset values done");
		for (int lvl = 0; lvl < 4; lvl++) begin
			access(1'b1, transient_pkg::CTRL_OFS, 32'(lvl));
			highPulse <= 1'b1;
			repeat (2) @(posedge clock);
			check(lagPwm, 1'b0);
			repeat (6) @(posedge clock);
			check(gate, 1'b1);
			check(lagPwm, 1'b1);
			curPulse({peak[lvl], 2'b00});
			check(gate, 1'b1);
			curPulse({peak[lvl], 2'b00} + 10'h001);
			check(gate, 1'b0);
			highPulse <= 1'b0;
			repeat (8) @(posedge clock);
			highPulse <= 1'b1;
			repeat (8) @(posedge clock);
			check(gate, 1'b1);
			highPulse <= 1'b0;
			repeat (8) @(posedge clock);
		end
		$display("Test peak limit done");
		access(1'b1, transient_pkg::VCODE_OFS, 32'h100);
		access(1'b1, transient_pkg::MIDLINE_OFS, 32'h10);
		access(1'b1, transient_pkg::ALARM_OFS_OFS, 32'h0306);
		access(1'b0, transient_pkg::STATUS_OFS, 32'h0);
		check(rd[31:16], 32'hF0);
		sample(10'h0F7);
		check(overAlarm, 1'b1);
		sample(10'h0F6);
		check(overAlarm, 1'b0);
		sample(10'h0EC);
		check(underAlarm, 1'b1);
		sample(10'h0F7);
		check(underAlarm, 1'b0);
		check(mode, 2'h1);
		sample(10'h0ED);
		check(underAlarm, 1'b0);
		repeat (8) @(posedge clock);
		check(mode, 2'h0);
		$display("Test alarm window done");
		access(1'b1, transient_pkg::VCODE_OFS, 32'h120);
		access(1'b0, transient_pkg::STATUS_OFS, 32'h0);
		check(rd[31:16], 32'h110);
		sample(10'h0ED);
		check(underAlarm, 1'b1);
		repeat (4) @(posedge clock);
		rdChk(transient_pkg::FAULT_OFS, 32'h2);
		check(alert, 1'b1);
		sample(10'h110);
		access(1'b1, transient_pkg::FAULT_OFS, 32'hF);
		rdChk(transient_pkg::FAULT_OFS, 32'h0);
		sample(10'h130);
		repeat (4) @(posedge clock);
		rdChk(transient_pkg::FAULT_OFS, 32'h4);
		sample(10'h110);
		access(1'b1, transient_pkg::FAULT_OFS, 32'hF);
		uvPin <= 1'b1;
		otPin <= 1'b1;
		repeat (8) @(posedge clock);
		rdChk(transient_pkg::FAULT_OFS, 32'h9);
		access(1'b1, transient_pkg::FAULT_OFS, 32'hF);
		rdChk(transient_pkg::FAULT_OFS, 32'h9);
		uvPin <= 1'b0;
		otPin <= 1'b0;
		repeat (8) @(posedge clock);
		access(1'b1, transient_pkg::FAULT_OFS, 32'hF);
		rdChk(transient_pkg::FAULT_OFS, 32'h0);
		$display("Test fault bits done");
		highPulse <= 1'b1;
		repeat (8) @(posedge clock);
		check(pwm, 1'b0);
		check(gate, 1'b0);
		$display("Test shutdown done");
		finalReport;
	end

	initial begin
		repeat (10000) @(posedge clock);
		failCount++;
		finalReport;
	end
endmodule // tb

// File: hdl/peak_limiter.sv
// Purpose: Pulse-by-pulse high-side current limit
// Assumes: Period start is a one-cycle pulse at the rise of the command
// Notes:   A trip holds the switch off until the next period
`timescale 1ns/1ps
module peak_limiter #(
	parameter int CUR_W = 10
) (
	// Clock and reset
	input wire logic             clock,
	input wire logic             arst_n,
	input wire logic             ce,
	// Command and current
	input wire logic             highCmd,
	input wire logic             periodStart,
	input wire logic [CUR_W-1:0] curCode,
	input wire logic             curValid,
	input wire logic [CUR_W-1:0] peakLimit,
	// Switch
	output logic                 gate,
	output logic                 limited
);
	logic gateQ, gateD, limitedQ, limitedD, trip;

	// ==========================================================
	// Trip and gate
	always_comb begin
		trip     = curValid && highCmd && (curCode > peakLimit);
		limitedD = limitedQ;
		if (periodStart) begin
			limitedD = 1'b0;
		end
		if (trip) begin
			limitedD = 1'b1;
		end
		gateD = highCmd && !limitedD;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gateQ    <= 1'b0;
			limitedQ <= 1'b0;
		end else if (ce) begin
			gateQ    <= gateD;
			limitedQ <= limitedD;
		end
	end

	assign gate    = gateQ;
	assign limited = limitedQ;

	// ==========================================================
	// Checks
	peak_trip_off_a: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && trip) |=> !gate && limited)
		else $error("high side stayed on after a peak trip");
	peak_rest_period_a: assert property (@(posedge clock) disable iff (!arst_n)
		(limited && !periodStart) |=> limited && !gate)
		else $error("peak limit released before the next period");
endmodule // peak_limiter

// File: hdl/transient_pkg.sv
// Purpose: Shared constants of the transient sense and protection stage
// Assumes: Registers sit at byte addresses on a 32-bit bus
// Notes:   Voltage codes and offsets count steps of the sense converter
package transient_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] VCODE_OFS     = 8'h04;
	localparam logic [7:0] ALARM_OFS_OFS = 8'h08;
	localparam logic [7:0] MIDLINE_OFS   = 8'h0C;
	localparam logic [7:0] PROT_OFS_OFS  = 8'h10;
	localparam logic [7:0] FAULT_OFS     = 8'h14;
	localparam logic [7:0] STATUS_OFS    = 8'h18;

	// ==========================================================
	// Reset values
	localparam logic [1:0]  CTRL_RST      = 2'h0;
	localparam logic [15:0] VCODE_RST     = 16'h0000;
	localparam logic [7:0]  MIDLINE_RST   = 8'h00;
	localparam logic [15:0] ALARM_OFS_RST = 16'h0404;
	localparam logic [15:0] PROT_OFS_RST  = 16'h1F1F;

	// ==========================================================
	// Field positions
	localparam int OVER_LSB   = 0;
	localparam int UNDER_LSB  = 8;
	localparam int OFS_W      = 8;
	localparam int FLT_IUV    = 0;
	localparam int FLT_OUV    = 1;
	localparam int FLT_OOV    = 2;
	localparam int FLT_OT     = 3;
	localparam int FAULT_W    = 4;
	localparam int REF_LSB    = 16;

	// ==========================================================
	// Offset step size in microvolts
	localparam int STEP_UV = 7500;

	// ==========================================================
	// Peak current levels, as eighths of full scale in the top byte
	localparam logic [7:0] PEAK_LVL0 = 8'h80;
	localparam logic [7:0] PEAK_LVL1 = 8'hA0;
	localparam logic [7:0] PEAK_LVL2 = 8'hC0;
	localparam logic [7:0] PEAK_LVL3 = 8'hE0;

	// ==========================================================
	// Bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_e;

endpackage

// File: hdl/transient_response_fault_control.sv
// Purpose: Transient alarm sensing, output window protection and fault register
// Assumes: Sense and current codes arrive from converters on this clock
// Notes:   Pins pass four flip-flops before use
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module transient_response_fault_control #(
	parameter int SENSE_W = 10,
	parameter int CUR_W   = 10
) (
	// Clock and reset
	input wire logic               clock,
	input wire logic               arst_n,
	input wire logic               ce,
	// Register bus
	input wire logic [7:0]         address,
	input wire logic               read,
	input wire logic               write,
	input wire logic [31:0]        writedata,
	input wire logic [3:0]         byteenable,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// Converter samples
	input wire logic [SENSE_W-1:0] senseCode,
	input wire logic               senseValid,
	input wire logic [CUR_W-1:0]   curCode,
	input wire logic               curValid,
	// Pins
	input wire logic               highSideCmd,
	input wire logic               inputUnderVoltPin,
	input wire logic               overTempPin,
	// Alarms and drive
	output logic                   overshootAlarm,
	output logic                   undershootAlarm,
	output logic                   highSideGate,
	output logic                   faultAlert
);

	// ==========================================================
	// Parameter checks
	if (SENSE_W < 8 || SENSE_W > 16 || CUR_W < 8 || CUR_W > 16) begin : g_bad_width
		$error("SENSE_W and CUR_W must lie in 8..16");
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// Functions
	function automatic logic [SENSE_W:0] addOfs(input logic [SENSE_W-1:0] a, input logic [7:0] b);
		addOfs = {1'b0, a} + (SENSE_W+1)'(b);
	endfunction

	function automatic logic [SENSE_W:0] subOfs(input logic [SENSE_W-1:0] a, input logic [7:0] b);
		subOfs = ({1'b0, a} >= (SENSE_W+1)'(b)) ? ({1'b0, a} - (SENSE_W+1)'(b)) : '0;
	endfunction

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		mergeBytes = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				mergeBytes[8*b +: 8] = wd[8*b +: 8];
			end
		end
	endfunction

	function automatic logic [7:0] peakLevel(input logic [1:0] sel);
		case (sel)
			2'h0: peakLevel = transient_pkg::PEAK_LVL0;
			2'h1: peakLevel = transient_pkg::PEAK_LVL1;
			2'h2: peakLevel = transient_pkg::PEAK_LVL2;
			default: peakLevel = transient_pkg::PEAK_LVL3;
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [2:0] pinRaw, s1Q, s2Q, s3Q, pinQ, pinD;
	logic       pwmPrevQ, periodStart;

	assign pinRaw = {overTempPin, inputUnderVoltPin, highSideCmd};

	for (genvar i = 0; i < 3; i++) begin : g_pin
		assign pinD[i] = (s2Q[i] == s3Q[i]) ? s2Q[i] : pinQ[i];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s1Q      <= 3'h0;
			s2Q      <= 3'h0;
			s3Q      <= 3'h0;
			pinQ     <= 3'h0;
			pwmPrevQ <= 1'b0;
		end else if (ce) begin
			s1Q      <= pinRaw;
			s2Q      <= s1Q;
			s3Q      <= s2Q;
			pinQ     <= pinD;
			pwmPrevQ <= pinQ[0];
		end
	end

	assign periodStart = pinQ[0] && !pwmPrevQ;

	// ==========================================================
	// Registers
	logic [1:0]                ctrlQ, ctrlD;
	logic [SENSE_W-1:0]        vcodeQ, vcodeD, alarmRef;
	logic [7:0]                midQ, midD;
	logic [15:0]               alarmOfsQ, alarmOfsD, protOfsQ, protOfsD;
	logic [3:0]                faultQ, faultD, faultSet, faultClr;
	logic [31:0]               readdataQ, readdataD, curVal, merged;
	logic                      faultAlertQ, faultAlertD, wrHit, peakLimited, pwmGate;
	logic [CUR_W-1:0]          peakLimit;
	transient_pkg::bus_state_e busStateQ, busStateD;

	window_if #(.W(SENSE_W)) alarmWin ();
	window_if #(.W(SENSE_W)) protWin ();

	assign alarmRef = SENSE_W'(subOfs(vcodeQ, midQ));
	assign wrHit    = write && (busStateQ == transient_pkg::BUS_DONE);

	// Value of the register at the current address
	always_comb begin
		curVal = 32'h0000_0000;
		if (address == transient_pkg::CTRL_OFS) begin
			curVal[1:0] = ctrlQ;
		end else if (address == transient_pkg::VCODE_OFS) begin
			curVal[SENSE_W-1:0] = vcodeQ;
		end else if (address == transient_pkg::ALARM_OFS_OFS) begin
			curVal[15:0] = alarmOfsQ;
		end else if (address == transient_pkg::MIDLINE_OFS) begin
			curVal[7:0] = midQ;
		end else if (address == transient_pkg::PROT_OFS_OFS) begin
			curVal[15:0] = protOfsQ;
		end else if (address == transient_pkg::FAULT_OFS) begin
			curVal[transient_pkg::FAULT_W-1:0] = faultQ;
		end else if (address == transient_pkg::STATUS_OFS) begin
			curVal[4:0] = {pinQ[0], peakLimited, highSideGate, undershootAlarm, overshootAlarm};
			curVal[transient_pkg::REF_LSB +: 16] = 16'(alarmRef);
		end
	end

	// Next register values
	always_comb begin
		ctrlD       = ctrlQ;
		vcodeD      = vcodeQ;
		midD        = midQ;
		alarmOfsD   = alarmOfsQ;
		protOfsD    = protOfsQ;
		readdataD   = readdataQ;
		busStateD   = busStateQ;
		merged      = mergeBytes(curVal, writedata, byteenable);
		faultClr    = 4'h0;
		case (busStateQ)
			transient_pkg::BUS_IDLE: begin
				if (read || write) begin
					busStateD = transient_pkg::BUS_DONE;
					readdataD = read ? curVal : 32'h0000_0000;
				end
			end
			default: begin
				busStateD = transient_pkg::BUS_IDLE;
			end
		endcase
		if (wrHit) begin
			if (address == transient_pkg::CTRL_OFS) begin
				ctrlD = merged[1:0];
			end else if (address == transient_pkg::VCODE_OFS) begin
				vcodeD = merged[SENSE_W-1:0];
			end else if (address == transient_pkg::ALARM_OFS_OFS) begin
				alarmOfsD = merged[15:0];
			end else if (address == transient_pkg::MIDLINE_OFS) begin
				midD = merged[7:0];
			end else if (address == transient_pkg::PROT_OFS_OFS) begin
				protOfsD = merged[15:0];
			end else if (address == transient_pkg::FAULT_OFS) begin
				faultClr = writedata[3:0] & {4{byteenable[0]}};
			end
		end
		faultSet = 4'h0;
		faultSet[transient_pkg::FLT_IUV] = pinQ[1];
		faultSet[transient_pkg::FLT_OUV] = protWin.below;
		faultSet[transient_pkg::FLT_OOV] = protWin.above;
		faultSet[transient_pkg::FLT_OT]  = pinQ[2];
		faultD      = (faultQ & ~faultClr) | faultSet;
		faultAlertD = |faultD;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrlQ       <= transient_pkg::CTRL_RST;
			vcodeQ      <= transient_pkg::VCODE_RST[SENSE_W-1:0];
			midQ        <= transient_pkg::MIDLINE_RST;
			alarmOfsQ   <= transient_pkg::ALARM_OFS_RST;
			protOfsQ    <= transient_pkg::PROT_OFS_RST;
			faultQ      <= 4'h0;
			readdataQ   <= 32'h0000_0000;
			busStateQ   <= transient_pkg::BUS_IDLE;
			faultAlertQ <= 1'b0;
		end else if (ce) begin
			ctrlQ       <= ctrlD;
			vcodeQ      <= vcodeD;
			midQ        <= midD;
			alarmOfsQ   <= alarmOfsD;
			protOfsQ    <= protOfsD;
			faultQ      <= faultD;
			readdataQ   <= readdataD;
			busStateQ   <= busStateD;
			faultAlertQ <= faultAlertD;
		end
	end

	// ==========================================================
	// Windows
	assign alarmWin.sample  = senseCode;
	assign alarmWin.valid   = senseValid;
	assign alarmWin.hiLimit = addOfs(alarmRef, alarmOfsQ[transient_pkg::OVER_LSB +: transient_pkg::OFS_W]);
	assign alarmWin.loLimit = subOfs(alarmRef, alarmOfsQ[transient_pkg::UNDER_LSB +: transient_pkg::OFS_W]);
	assign protWin.sample   = senseCode;
	assign protWin.valid    = senseValid;
	assign protWin.hiLimit  = addOfs(alarmRef, protOfsQ[transient_pkg::OVER_LSB +: transient_pkg::OFS_W]);
	assign protWin.loLimit  = subOfs(alarmRef, protOfsQ[transient_pkg::UNDER_LSB +: transient_pkg::OFS_W]);

	window_compare u_alarm (
		.clock  (clock),
		.arst_n (arst_n),
		.ce     (ce),
		.win    (alarmWin)
	);

	window_compare u_prot (
		.clock  (clock),
		.arst_n (arst_n),
		.ce     (ce),
		.win    (protWin)
	);

	// ==========================================================
	// Peak limit
	assign peakLimit = CUR_W'(peakLevel(ctrlQ)) << (CUR_W - 8);

	peak_limiter #(.CUR_W(CUR_W)) u_peak (
		.clock       (clock),
		.arst_n      (arst_n),
		.ce          (ce),
		.highCmd     (pinQ[0]),
		.periodStart (periodStart),
		.curCode     (curCode),
		.curValid    (curValid),
		.peakLimit   (peakLimit),
		.gate        (pwmGate),
		.limited     (peakLimited)
	);

	// ==========================================================
	// Outputs
	assign readdata        = readdataQ;
	assign waitrequest     = busStateQ[0];
	assign overshootAlarm  = alarmWin.above;
	assign undershootAlarm = alarmWin.below;
	assign highSideGate    = pwmGate;
	assign faultAlert      = faultAlertQ;

	// ==========================================================
	// Checks
	logic                 ovRaw, unRaw, oovRaw;
	logic [SENSE_W-1:0]   nextRef;
	assign ovRaw   = {1'b0, senseCode} > alarmWin.hiLimit;
	assign unRaw   = {1'b0, senseCode} < alarmWin.loLimit;
	assign oovRaw  = {1'b0, senseCode} > protWin.hiLimit;
	assign nextRef = SENSE_W'(subOfs(writedata[SENSE_W-1:0], midQ));

	overshoot_follows_a: assert property ((ce && senseValid) |=> overshootAlarm == $past(ovRaw))
		else $error("overshoot alarm does not follow the sensed voltage");
	undershoot_sets_a: assert property ((ce && senseValid && unRaw) |=> undershootAlarm)
		else $error("undershoot alarm missing below threshold");
	undershoot_clears_a: assert property ((ce && senseValid && !unRaw) |=> !undershootAlarm)
		else $error("undershoot alarm held above threshold");
	offset_steps_a: assert property ((ce && wrHit && address == transient_pkg::ALARM_OFS_OFS
		&& byteenable[0] && alarmRef < (SENSE_W)'(2 ** SENSE_W - 256))
		|=> (alarmWin.hiLimit - {1'b0, alarmRef}) == (SENSE_W+1)'($past(writedata[7:0])))
		else $error("overshoot offset not applied in whole steps");
	ref_tracks_code_a: assert property ((ce && wrHit && address == transient_pkg::VCODE_OFS
		&& &byteenable[1:0]) |=> alarmRef == $past(nextRef))
		else $error("alarm reference lags the voltage code");
	midpoint_quiet_a: assert property ((ce && senseValid && senseCode == alarmRef
		&& alarmOfsQ[7:0] != 8'h00 && alarmOfsQ[15:8] != 8'h00) |=> !overshootAlarm && !undershootAlarm)
		else $error("alarm raised at the reference midpoint");
	overvolt_fault_a: assert property ((ce && senseValid && oovRaw) ##1 ce
		|=> faultQ[transient_pkg::FLT_OOV])
		else $error("output overvoltage did not set its fault bit");
	fault_set_wins_a: assert property ((ce && pinQ[2] && wrHit && address == transient_pkg::FAULT_OFS)
		|=> faultQ[transient_pkg::FLT_OT] && faultAlert)
		else $error("over temperature fault lost to a clear");
	peak_select_a: assert property ($changed(peakLimit) |-> $past(wrHit && address == transient_pkg::CTRL_OFS))
		else $error("peak limit moved without a control write");
endmodule // transient_response_fault_control

// File: hdl/window_compare.sv
// Purpose: Registered window comparator on a sampled code
// Assumes: Sample and limits come from logic on the same clock
// Notes:   Levels change only on a valid sample
`timescale 1ns/1ps
module window_compare (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// Window
	window_if.cmp    win
);
	logic aboveQ, aboveD, belowQ, belowD;

	// ==========================================================
	// Compare
	always_comb begin
		aboveD = aboveQ;
		belowD = belowQ;
		if (win.valid) begin
			aboveD = {1'b0, win.sample} > win.hiLimit;
			belowD = {1'b0, win.sample} < win.loLimit;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aboveQ <= 1'b0;
			belowQ <= 1'b0;
		end else if (ce) begin
			aboveQ <= aboveD;
			belowQ <= belowD;
		end
	end

	assign win.above = aboveQ;
	assign win.below = belowQ;

	// ==========================================================
	// Checks
	window_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
		(!ce || !win.valid) |=> $stable(win.above) && $stable(win.below))
		else $error("window level moved without a valid sample");
endmodule // window_compare

// File: hdl/window_if.sv
// Purpose: Carries one window comparison between its owner and its comparator
// Assumes: Limits are one bit wider than the sample
// Notes:   Above and below are registered inside the comparator
`timescale 1ns/1ps
interface window_if #(parameter int W = 10);
	logic [W-1:0] sample;
	logic         valid;
	logic [W:0]   hiLimit;
	logic [W:0]   loLimit;
	logic         above;
	logic         below;
	modport cmp (input sample, valid, hiLimit, loLimit, output above, below);
	modport ctl (output sample, valid, hiLimit, loLimit, input above, below);
endinterface
